//--- common/pyrol_pkg.sv
package pyrol_pkg;

	// ------------------------------------------------------------
	// Packet layout
	// ------------------------------------------------------------
	localparam int PKT_W    = 28;
	localparam int CH_W     = 14;
	localparam int IR_MSB   = 27;
	localparam int IR_LSB   = 14;
	localparam int TEMP_MSB = 13;
	localparam int TEMP_LSB = 0;
	localparam int BITCNT_W = 5;

	// ------------------------------------------------------------
	// Out of range window of the infrared channel
	// ------------------------------------------------------------
	localparam logic [CH_W-1:0] OOR_LOW  = 14'h01FF;
	localparam logic [CH_W-1:0] OOR_HIGH = 14'h3E01;

	// ------------------------------------------------------------
	// Timing, in ns, and cycle counts at the 50 MHz clock
	// ------------------------------------------------------------
	localparam int CLK_NS                = 20;
	localparam int UPDATE_TIME_NS        = 1250000;
	localparam int INTERRUPT_PERIOD_NS   = 14600000;
	localparam int DISCHARGE_NS          = 16000000;
	localparam int INT_PULSE_NS          = 20000;
	localparam int HOST_PULSE_HIGH_MAX_NS = 2000;
	localparam int BIT_DRIVE_NS          = 20000;

	localparam int UPDATE_CYC    = (UPDATE_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int INTERRUPT_CYC = (INTERRUPT_PERIOD_NS + CLK_NS - 1) / CLK_NS;
	localparam int DISCHARGE_CYC = DISCHARGE_NS / CLK_NS;
	localparam int INT_PULSE_CYC = INT_PULSE_NS / CLK_NS;
	localparam int HOST_HI_CYC   = (HOST_PULSE_HIGH_MAX_NS + CLK_NS - 1) / CLK_NS;
	localparam int BIT_DRIVE_CYC = BIT_DRIVE_NS / CLK_NS;

	localparam int TMR_W      = 20;
	localparam int FIFO_DEPTH = 32;

	// ------------------------------------------------------------
	// Link states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PYROL_IDLE,
		PYROL_INT_PULSE,
		PYROL_WAIT_LOW,
		PYROL_START_HI,
		PYROL_BIT_WAIT,
		PYROL_BIT_DELAY,
		PYROL_BIT_DRIVE,
		PYROL_DONE_LOW
	} pyrol_state_t;

endpackage

//--- rtl/pyrol_link.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------
module pyrol_fifo
	import pyrol_pkg::*;
#(
	parameter int W     = PKT_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Filling side
	input  wire logic         in_valid,
	output var  logic         in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output var  logic         out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0]   count_ff;
	logic [AW:0]   nxt_count;
	wire           push = in_valid && in_ready;
	wire           pop  = out_valid && out_ready;

	assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data  = mem[rd_ptr_ff];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr_ff <= push ? AW'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
			rd_ptr_ff <= pop ? AW'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
			count_ff  <= nxt_count;
			in_ready  <= nxt_count < (AW+1)'(DEPTH);
			out_valid <= nxt_count != '0;
		end
	end
endmodule

// Contract
// - Packet: infrared 27..14, temperature 13..0
// - Both values unsigned 14-bit integers
// - Out-of-range infrared shorts input ~16 ms
// - Transfer begins with rising edge on wire
// - No forced start 14.6 ms: sensor drives high
// - Interrupt pulses recur periodically, typically 14.6 ms
// - Per host edge, drive low for 0
// - Long low aborts packet, values refresh
module pyrol_link
	import pyrol_pkg::*;
#(
	parameter logic [TMR_W-1:0] UPDATE_CYCLES    = TMR_W'(UPDATE_CYC),
	parameter logic [TMR_W-1:0] INTERRUPT_CYCLES = TMR_W'(INTERRUPT_CYC),
	parameter logic [TMR_W-1:0] DISCHARGE_CYCLES = TMR_W'(DISCHARGE_CYC),
	parameter int               DEPTH            = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic            clock,
	input  wire logic            rst_n,
	// Converter samples
	input  wire logic            sample_valid,
	output var  logic            sample_ready,
	input  wire logic [CH_W-1:0] infrared_reading,
	input  wire logic [CH_W-1:0] temp_reading,
	// Single-wire link
	input  wire logic            link_in,
	output var  logic            link_out_ff,
	output var  logic            link_oe_ff,
	// Sensing element discharge
	output var  logic            discharge_ff
);
	// ------------------------------------------------------------
	// Wire synchroniser and edge detect
	// ------------------------------------------------------------
	logic link_s1_ff;
	logic link_s2_ff;
	logic link_prev_ff;
	wire  link_hi   = link_s2_ff;
	wire  link_rise = link_s2_ff && !link_prev_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link_s1_ff   <= 1'b0;
			link_s2_ff   <= 1'b0;
			link_prev_ff <= 1'b0;
		end else begin
			link_s1_ff   <= link_in;
			link_s2_ff   <= link_s1_ff;
			link_prev_ff <= link_s2_ff;
		end
	end

	// ------------------------------------------------------------
	// Sample buffer and range check
	// ------------------------------------------------------------
	logic [PKT_W-1:0] fifo_out_data;
	logic             fifo_out_valid;
	wire  [PKT_W-1:0] sample_word = {infrared_reading, temp_reading};
	wire              sample_take = sample_valid && sample_ready;
	wire              out_of_range = (infrared_reading < OOR_LOW) || (infrared_reading > OOR_HIGH);
	wire              refresh;

	// Stalls the converter when the host reads slower than samples arrive
	pyrol_fifo #(
		.W     (PKT_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.in_data   (sample_word),
		.out_valid (fifo_out_valid),
		.out_ready (refresh),
		.out_data  (fifo_out_data)
	);

	logic [TMR_W-1:0] dis_cnt_ff;
	wire              dis_start = sample_take && out_of_range;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dis_cnt_ff   <= '0;
			discharge_ff <= 1'b0;
		end else begin
			dis_cnt_ff   <= dis_start ? DISCHARGE_CYCLES : (dis_cnt_ff != '0 ? dis_cnt_ff - 1'b1 : '0);
			discharge_ff <= dis_start || dis_cnt_ff > 1;
		end
	end

	// ------------------------------------------------------------
	// Link sequencer
	// ------------------------------------------------------------
	pyrol_state_t         state_ff;
	pyrol_state_t         nxt_state;
	logic [TMR_W-1:0]     tmr_ff;
	logic [TMR_W-1:0]     lo_cnt_ff;
	logic [PKT_W-1:0]     shift_ff;
	logic [PKT_W-1:0]     pkt_ff;
	logic [BITCNT_W-1:0]  bits_left_ff;

	wire  waiting_low = (state_ff == PYROL_BIT_WAIT) || (state_ff == PYROL_DONE_LOW);
	wire  update_due  = waiting_low && !link_hi && lo_cnt_ff >= UPDATE_CYCLES;
	assign refresh = update_due;
	wire  [PKT_W-1:0] pkt_next = fifo_out_valid ? fifo_out_data : pkt_ff;
	wire  idle_expire = (state_ff == PYROL_IDLE) && !link_rise && tmr_ff >= INTERRUPT_CYCLES;
	wire  delay_done  = (state_ff == PYROL_BIT_DELAY) && tmr_ff >= TMR_W'(HOST_HI_CYC);
	wire  drive_done  = (state_ff == PYROL_BIT_DRIVE) && tmr_ff >= TMR_W'(BIT_DRIVE_CYC);
	wire  last_bit    = bits_left_ff == BITCNT_W'(1);
	wire  nxt_oe;
	wire  state_moves = nxt_state != state_ff;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			PYROL_IDLE: begin
				if (link_rise) begin
					nxt_state = PYROL_START_HI;
				end else if (idle_expire) begin
					nxt_state = PYROL_INT_PULSE;
				end
			end
			PYROL_INT_PULSE: begin
				if (tmr_ff >= TMR_W'(INT_PULSE_CYC)) begin
					nxt_state = PYROL_WAIT_LOW;
				end
			end
			PYROL_WAIT_LOW, PYROL_START_HI: begin
				if (!link_hi) begin
					nxt_state = PYROL_BIT_WAIT;
				end
			end
			PYROL_BIT_WAIT: begin
				if (update_due) begin
					nxt_state = PYROL_IDLE;
				end else if (link_rise) begin
					nxt_state = PYROL_BIT_DELAY;
				end
			end
			PYROL_BIT_DELAY: begin
				if (delay_done) begin
					nxt_state = PYROL_BIT_DRIVE;
				end
			end
			PYROL_BIT_DRIVE: begin
				if (drive_done) begin
					nxt_state = last_bit ? PYROL_DONE_LOW : PYROL_BIT_WAIT;
				end
			end
			PYROL_DONE_LOW: begin
				if (update_due) begin
					nxt_state = PYROL_IDLE;
				end
			end
		endcase
	end

	// Drive only for an interrupt pulse or a zero bit; a one is the host's high left floating
	assign nxt_oe = (nxt_state == PYROL_INT_PULSE) ||
	                ((nxt_state == PYROL_BIT_DRIVE) && !shift_ff[PKT_W-1]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= PYROL_IDLE;
			tmr_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff   <= state_moves ? '0 : tmr_ff + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lo_cnt_ff <= '0;
		end else begin
			lo_cnt_ff <= (waiting_low && !link_hi) ? lo_cnt_ff + 1'b1 : '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_ff     <= '0;
			pkt_ff       <= '0;
			bits_left_ff <= BITCNT_W'(PKT_W);
		end else if (refresh) begin
			// Empty buffer: replay the last loaded packet, not the shifted-out remains
			shift_ff     <= pkt_next;
			pkt_ff       <= pkt_next;
			bits_left_ff <= BITCNT_W'(PKT_W);
		end else if (drive_done) begin
			shift_ff     <= {shift_ff[PKT_W-2:0], 1'b0};
			bits_left_ff <= bits_left_ff - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link_out_ff <= 1'b0;
			link_oe_ff  <= 1'b0;
		end else begin
			link_out_ff <= nxt_state == PYROL_INT_PULSE;
			link_oe_ff  <= nxt_oe;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	pkt_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		refresh && fifo_out_valid |=> shift_ff == $past(fifo_out_data) && bits_left_ff == BITCNT_W'(PKT_W))
		else $error("packet not loaded from buffer on refresh");

	oor_start_a: assert property (@(posedge clock) disable iff (!rst_n)
		dis_start |=> discharge_ff [*8])
		else $error("discharge not held after out of range sample");

	in_range_a: assert property (@(posedge clock) disable iff (!rst_n)
		sample_take && infrared_reading >= OOR_LOW && infrared_reading <= OOR_HIGH && dis_cnt_ff == '0
		|=> !discharge_ff)
		else $error("discharge raised for in range sample");

	start_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
		state_ff == PYROL_IDLE && link_rise |=> state_ff == PYROL_START_HI && !link_oe_ff)
		else $error("rising edge did not start a transfer");

	int_fire_a: assert property (@(posedge clock) disable iff (!rst_n)
		idle_expire |=> link_oe_ff && link_out_ff)
		else $error("no interrupt pulse after idle time");

	int_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(link_oe_ff && link_out_ff) |-> (link_oe_ff && link_out_ff) [*8])
		else $error("interrupt pulse too short");

	bit_level_a: assert property (@(posedge clock) disable iff (!rst_n)
		state_ff == PYROL_BIT_DRIVE |-> link_oe_ff == !shift_ff[PKT_W-1] && !link_out_ff)
		else $error("driven level does not match packet bit");

	bit_order_a: assert property (@(posedge clock) disable iff (!rst_n)
		drive_done && !refresh |=> shift_ff == {$past(shift_ff[PKT_W-2:0]), 1'b0})
		else $error("packet not shifted msb first");

	abort_a: assert property (@(posedge clock) disable iff (!rst_n)
		update_due |=> state_ff == PYROL_IDLE ##1 !link_oe_ff)
		else $error("long low did not end the packet");

	pkt_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
		refresh && !fifo_out_valid |=> shift_ff == $past(pkt_ff))
		else $error("packet not replayed on refresh with empty buffer");
endmodule

`default_nettype wire

//--- bench/pyrol_host.sv
`timescale 1ns/1ps
`default_nettype none

module pyrol_host (
	// Clock and resolved wire
	input  wire logic clock,
	input  wire logic wire_lvl,
	// Host drive
	output var  logic host_oe,
	output var  logic host_out
);
	initial begin
		host_oe  = 1'b0;
		host_out = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic drive(input logic oe, input logic v, input int n);
		host_oe  = oe;
		host_out = v;
		cyc(n);
	endtask

	// ------------------------------------------------------------
	// Host sequences
	// ------------------------------------------------------------
	task automatic start_forced();
		drive(1'b1, 1'b1, 5500);
		drive(1'b1, 1'b0, 50);
	endtask

	// 1200-cycle bit period: the device's drive has ended before the host pulls low
	task automatic read_bits(input int n, output logic [27:0] got);
		got = '0;
		for (int i = 0; i < n; i++) begin
			drive(1'b1, 1'b1, 50);
			drive(1'b0, 1'b0, 450);
			got = {got[26:0], wire_lvl};
			cyc(670);
			drive(1'b1, 1'b0, 30);
		end
	endtask

	task automatic long_low();
		drive(1'b1, 1'b0, 4500);
		host_oe = 1'b0;
	endtask
endmodule

`default_nettype wire

//--- bench/pyrol_link_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module pyrol_link_tb;
	import pyrol_pkg::*;

	localparam logic [PKT_W-1:0] PKT_A = {14'h2ABC, 14'h1234};
	localparam logic [PKT_W-1:0] PKT_B = {14'h1555, 14'h3FFF};

	// Shortened timing keeps the run short; the design keeps its real defaults
	localparam logic [TMR_W-1:0] UPD_CYC_TB = 20'h00FA0;
	localparam logic [TMR_W-1:0] INT_CYC_TB = 20'h00BB8;
	localparam logic [TMR_W-1:0] DIS_CYC_TB = 20'h00028;

	logic            clock        = 1'b0;
	logic            rst_n        = 1'b0;
	logic            sample_valid = 1'b0;
	logic [CH_W-1:0] ir           = '0;
	logic [CH_W-1:0] tmp          = '0;
	logic            wire_lvl     = 1'b0;
	logic            sample_ready;
	logic            link_out_ff;
	logic            link_oe_ff;
	logic            discharge_ff;
	logic            host_oe;
	logic            host_out;
	logic [PKT_W-1:0] got;
	int              failures     = 0;
	int              n_checks     = 0;

	always #10 clock = ~clock;

	// No pull resistor: an undriven wire keeps its last level
	always @* begin
		if (link_oe_ff)
			wire_lvl = link_out_ff;
		else if (host_oe)
			wire_lvl = host_out;
	end

	pyrol_link #(.UPDATE_CYCLES(UPD_CYC_TB), .INTERRUPT_CYCLES(INT_CYC_TB), .DISCHARGE_CYCLES(DIS_CYC_TB),
		.DEPTH(FIFO_DEPTH)) DUT (
		.clock(clock), .rst_n(rst_n), .sample_valid(sample_valid), .sample_ready(sample_ready),
		.infrared_reading(ir), .temp_reading(tmp), .link_in(wire_lvl),
		.link_out_ff(link_out_ff), .link_oe_ff(link_oe_ff), .discharge_ff(discharge_ff));

	pyrol_host h (.clock(clock), .wire_lvl(wire_lvl), .host_oe(host_oe), .host_out(host_out));

	task automatic final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic push(input logic [CH_W-1:0] a, input logic [CH_W-1:0] b);
		int k;
		k = 0;
		ir = a;
		tmp = b;
		sample_valid = 1'b1;
		while (sample_ready !== 1'b1) begin
			h.cyc(1);
			k++;
			if (k > 100) begin
				failures++;
				final_report();
			end
		end
		h.cyc(1);
		sample_valid = 1'b0;
		h.cyc(1);
	endtask

	task automatic wait_oe(input logic v, input int lim, output int k);
		k = 0;
		while (link_oe_ff !== v) begin
			h.cyc(1);
			k++;
			if (k > lim) begin
				failures++;
				final_report();
			end
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_abort();
		h.start_forced();
		h.read_bits(3, got);
		`CHK("abort bits", 28'h0000000, got)
		h.long_low();
		$display("abort test done");
	endtask

	task automatic t_forced();
		h.start_forced();
		h.read_bits(28, got);
		`CHK("forced packet", PKT_A, got)
		h.long_low();
		$display("forced test done");
	endtask

	task automatic t_interrupt();
		int k;
		wait_oe(1'b1, 3000, k);
		`CHK("interrupt delay", 1'b1, (k > 2300) && (k < 2600))
		`CHK("interrupt level", 1'b1, link_out_ff)
		wait_oe(1'b0, 1100, k);
		`CHK("interrupt pulse", 1'b1, (k > 950) && (k < 1050))
		h.drive(1'b1, 1'b0, 2750);
		h.read_bits(14, got);
		`CHK("interrupt infrared", PKT_B[27:14], got[13:0])
		h.long_low();
		$display("interrupt test done");
	endtask

	task automatic t_range();
		logic [CH_W-1:0] v [4] = '{14'h01FE, 14'h01FF, 14'h3E01, 14'h3E02};
		logic e [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++) begin
			push(v[i], 14'h0000);
			`CHK("discharge start", e[i], discharge_ff)
			h.cyc(35);
			`CHK("discharge hold", e[i], discharge_ff)
			h.cyc(10);
			`CHK("discharge end", 1'b0, discharge_ff)
		end
		$display("range test done");
	endtask

	// Four words already sit in the buffer from the range test
	task automatic t_fill();
		for (int i = 0; i < 28; i++)
			push(14'h2000, 14'(i));
		`CHK("full ready", 1'b0, sample_ready)
		sample_valid = 1'b1;
		h.cyc(10);
		`CHK("refused ready", 1'b0, sample_ready)
		sample_valid = 1'b0;
		h.start_forced();
		h.long_low();
		`CHK("drained ready", 1'b1, sample_ready)
		$display("fill test done");
	endtask

	initial begin
		repeat (110000) @(posedge clock);
		failures++;
		final_report();
	end

	initial begin
		h.cyc(12);
		`CHK("reset drive", 1'b0, link_oe_ff)
		rst_n = 1'b1;
		push(PKT_A[27:14], PKT_A[13:0]);
		push(PKT_B[27:14], PKT_B[13:0]);
		t_abort();
		t_forced();
		t_interrupt();
		t_range();
		t_fill();
		final_report();
	end
endmodule

`default_nettype wire
